// File: src/sia_irq_map.vh
/*
  Constants of the interrupt event aggregator: event bit positions, counts, pulse timing.
  Assumes inclusion by bare name from the aggregator source.
*/
`ifndef SIA_IRQ_MAP_VH
`define SIA_IRQ_MAP_VH
`define SIA_NUM_EVT 51
`define SIA_EVT_SUPPLY_LO 0
`define SIA_EVT_PREREG_LO 3
`define SIA_EVT_CORE_LO 9
`define SIA_EVT_REF_LO 13
`define SIA_EVT_AUX_LO 20
`define SIA_EVT_TRX_LO 25
`define SIA_EVT_GP_CHG_LO 30
`define SIA_EVT_GP_WU_LO 35
`define SIA_EVT_BUS_LO 40
`define SIA_EVT_HOST_REQ 45
`define SIA_EVT_TIMER 46
`define SIA_EVT_SPI_LO 47
`define SIA_NUM_SPI_EVT 4
`define SIA_SPI_CLK_COUNT 6'h10
`define SIA_PULSE_SHORT_NS 25000
`define SIA_PULSE_LONG_NS 100000
`define SIA_CLK_PERIOD_NS 10
`define SIA_PULSE_SHORT_CYC (`SIA_PULSE_SHORT_NS / `SIA_CLK_PERIOD_NS)
`define SIA_PULSE_LONG_CYC (`SIA_PULSE_LONG_NS / `SIA_CLK_PERIOD_NS)
`define SIA_ST_IDLE 2'h0
`define SIA_ST_PULSE 2'h1
`define SIA_ST_GAP 2'h2
`endif

// File: src/sia_irq_aggregator.v
/*
  Event aggregator for the safety power chip: latches event flags, masks events out of the pulse request and
  drives low pulses on the active-low interrupt output; also checks SPI frames.
  Pulse and gap lengths are counts of ref_clk_i cycles, set by parameters.
  The counter width covers the default long pulse.
  Assumes every detector input is a level from the same clock domain, except the
  SPI pins, which are asynchronous and synchronised here.
  Assumes the frame check inputs are valid in the cycle frame_done_i is high.
  Assumes the serial clock holds each level for at least three ref_clk_i cycles.
  Assumes mask, clear and config inputs come from logic on ref_clk_i.
  Assumes a source drops again before it can report a second event.
*/
`include "sia_irq_map.vh"
module sia_irq_aggregator #(
  parameter integer NUM_EVT = `SIA_NUM_EVT,
  parameter integer PULSE_SHORT_CYC = `SIA_PULSE_SHORT_CYC,
  parameter integer PULSE_LONG_CYC = `SIA_PULSE_LONG_CYC
) (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire init_phase_i,
  input wire cfg_write_i,
  input wire cfg_pulse_en_i,
  input wire cfg_pulse_long_i,
  input wire [NUM_EVT-1:0] evt_mask_i,
  input wire [NUM_EVT-1:0] flag_clear_i,
  input wire [2:0] supply_evt_i,
  input wire [5:0] pre_regulator_evt_i,
  input wire [3:0] core_evt_i,
  input wire [6:0] analog_ref_regulator_evt_i,
  input wire [4:0] auxiliary_regulator_evt_i,
  input wire [4:0] transceiver_supply_evt_i,
  input wire [4:0] gp_input_state_i,
  input wire [4:0] gp_input_wakeup_i,
  input wire bus_wakeup_event_i,
  input wire transceiver_overtemp_event_i,
  input wire receive_stuck_recessive_i,
  input wire transmit_stuck_dominant_i,
  input wire bus_stuck_dominant_i,
  input wire host_irq_cmd_i,
  input wire long_timer_expiry_event_i,
  input wire long_timer_func1_i,
  input wire external_pass_i,
  input wire chip_select_n_i,
  input wire spi_sclk_i,
  input wire main_sm_active_i,
  input wire frame_done_i,
  input wire frame_parity_ok_i,
  input wire frame_access_bad_i,
  input wire frame_init_write_i,
  input wire frame_secure_ok_i,
  input wire normal_mode_i,
  output wire irq_pulse_out_n_o,
  output wire [NUM_EVT-1:0] evt_flags_o,
  output wire cfg_pulse_en_o,
  output wire cfg_pulse_long_o
);
  // Wide enough for the long pulse at the full clock rate
  localparam integer CW = 17;
  reg [NUM_EVT-1:0] flag_q;
  wire [NUM_EVT-1:0] flag_d;
  reg [NUM_EVT-1:0] prev_q;
  reg [NUM_EVT-1:0] raw;
  wire [NUM_EVT-1:0] rise;

  reg cfg_en_q;
  reg cfg_long_q;

  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [CW-1:0] cnt_q;
  reg [CW-1:0] cnt_d;
  reg pend_q;
  reg pend_d;
  reg irq_n_q;

  reg [1:0] cs_sync_q;
  reg [1:0] sclk_sync_q;
  reg cs_prev_q;
  reg sclk_prev_q;
  reg [5:0] sclk_cnt_q;
  reg clk_err_q;

  wire cs_fall;
  wire cs_rise;
  wire sclk_rise;
  wire [CW-1:0] pulse_len;
  wire [CW-1:0] pulse_last;
  wire [`SIA_NUM_SPI_EVT-1:0] spi_evt;
  genvar gi;

  // One count down; the state machine tests for zero first, so its counts never wrap
  function [CW-1:0] cnt_dec;
    input [CW-1:0] v;
    begin
      cnt_dec = v - {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction

  // True on the last cycle of a pulse or gap
  function cnt_zero;
    input [CW-1:0] v;
    begin
      cnt_zero = (v == {CW{1'b0}});
    end
  endfunction

  // Unmasked new events; nothing is requested while pulses are disabled
  function new_req;
    input [NUM_EVT-1:0] edges;
    input [NUM_EVT-1:0] mask;
    input en;
    begin
      new_req = (|(edges & ~mask)) & en;
    end
  endfunction

  // Pin inputs pass two flops before any logic reads them
  // Reset to the idle pin levels so no false edge follows reset
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_sync_q <= 2'h3;
      sclk_sync_q <= 2'h0;
      cs_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_sync_q <= {cs_sync_q[0], chip_select_n_i};
      sclk_sync_q <= {sclk_sync_q[0], spi_sclk_i};
      cs_prev_q <= cs_sync_q[1];
      sclk_prev_q <= sclk_sync_q[1];
    end
  end
  assign cs_fall = cs_prev_q & ~cs_sync_q[1];
  assign cs_rise = ~cs_prev_q & cs_sync_q[1];
  // Serial clock edges only count while the chip is selected
  assign sclk_rise = ~sclk_prev_q & sclk_sync_q[1] & ~cs_sync_q[1];

  // Saturating count so long bursts cannot wrap back to 16
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_cnt_q <= 6'h00;
      clk_err_q <= 1'b0;
    end else begin
      clk_err_q <= 1'b0;
      if (cs_fall) begin
        sclk_cnt_q <= 6'h00;
      end else if (sclk_rise && sclk_cnt_q != 6'h3f) begin
        sclk_cnt_q <= sclk_cnt_q + 6'h01;
      end
      // Judged on deselect, so a short and a long frame look alike
      if (cs_rise && main_sm_active_i && sclk_cnt_q != `SIA_SPI_CLK_COUNT) begin
        clk_err_q <= 1'b1;
      end
    end
  end

  // Config is only accepted while initialising, then holds for all pulses
  // Out of reset pulses are enabled and short
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_en_q <= 1'b1;
      cfg_long_q <= 1'b0;
    end else if (cfg_write_i && init_phase_i) begin
      cfg_en_q <= cfg_pulse_en_i;
      cfg_long_q <= cfg_pulse_long_i;
    end
  end

  // Spare detector bits stay zero and never raise a flag
  always @* begin
    raw = {NUM_EVT{1'b0}};
    raw[`SIA_EVT_SUPPLY_LO +: 3] = supply_evt_i;
    raw[`SIA_EVT_PREREG_LO +: 6] = pre_regulator_evt_i;
    raw[`SIA_EVT_CORE_LO +: 4] = core_evt_i;
    raw[`SIA_EVT_REF_LO +: 6] = analog_ref_regulator_evt_i[5:0];
    raw[`SIA_EVT_REF_LO + 6] = analog_ref_regulator_evt_i[6] & external_pass_i;
    raw[`SIA_EVT_AUX_LO +: 5] = auxiliary_regulator_evt_i;
    // Limit timeouts only mean something with an external pass transistor
    raw[`SIA_EVT_AUX_LO + 1] = auxiliary_regulator_evt_i[1] & external_pass_i;
    raw[`SIA_EVT_TRX_LO +: 5] = transceiver_supply_evt_i;
    raw[`SIA_EVT_GP_CHG_LO +: 5] = gp_input_state_i;
    raw[`SIA_EVT_GP_WU_LO +: 5] = gp_input_wakeup_i;
    raw[`SIA_EVT_BUS_LO] = bus_wakeup_event_i;
    raw[`SIA_EVT_BUS_LO + 1] = transceiver_overtemp_event_i;
    raw[`SIA_EVT_BUS_LO + 2] = receive_stuck_recessive_i;
    raw[`SIA_EVT_BUS_LO + 3] = transmit_stuck_dominant_i;
    raw[`SIA_EVT_BUS_LO + 4] = bus_stuck_dominant_i;
    raw[`SIA_EVT_HOST_REQ] = host_irq_cmd_i;
    raw[`SIA_EVT_TIMER] = long_timer_expiry_event_i & long_timer_func1_i;
    raw[`SIA_EVT_SPI_LO +: `SIA_NUM_SPI_EVT] = spi_evt;
  end

  // Frame checks on bits 0, 2 and 3 count only in the cycle a finished frame is handed over; the clock count error comes from deselect
  assign spi_evt[0] = frame_done_i & main_sm_active_i & ~frame_secure_ok_i;
  assign spi_evt[1] = clk_err_q;
  assign spi_evt[2] = frame_done_i & (frame_access_bad_i |
    (frame_init_write_i & normal_mode_i));
  assign spi_evt[3] = frame_done_i & main_sm_active_i & ~frame_parity_ok_i;

  // State-change events fire on either edge; every other source fires on its rise
  generate
    for (gi = 0; gi < NUM_EVT; gi = gi + 1) begin : g_edge
      if (gi >= `SIA_EVT_GP_CHG_LO && gi < `SIA_EVT_GP_CHG_LO + 5) begin : g_any
        assign rise[gi] = raw[gi] ^ prev_q[gi];
      end else begin : g_up
        assign rise[gi] = raw[gi] & ~prev_q[gi];
      end
    end
  endgenerate

  // A set in the same cycle as a clear wins, so no event is ever lost
  assign flag_d = (flag_q & ~flag_clear_i) | rise;

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_q <= {NUM_EVT{1'b0}};
      flag_q <= {NUM_EVT{1'b0}};
    end else begin
      prev_q <= raw;
      flag_q <= flag_d;
    end
  end

  // A gap of one pulse length plus the idle cycle separates back-to-back pulses so each is visible
  assign pulse_len = cfg_long_q ? PULSE_LONG_CYC[CW-1:0] : PULSE_SHORT_CYC[CW-1:0];
  // Counters load one less because the loading cycle already counts
  assign pulse_last = cnt_dec(pulse_len);

  // Events seen during a pulse or its gap fold into one further pulse
  always @* begin
    st_d = st_q;
    cnt_d = cnt_q;
    pend_d = pend_q | new_req(rise, evt_mask_i, cfg_en_q);
    case (st_q)
      `SIA_ST_IDLE: begin
        if (pend_q) begin
          st_d = `SIA_ST_PULSE;
          cnt_d = pulse_last;
          pend_d = new_req(rise, evt_mask_i, cfg_en_q);
        end
      end
      `SIA_ST_PULSE: begin
        if (cnt_zero(cnt_q)) begin
          st_d = `SIA_ST_GAP;
          cnt_d = pulse_last;
        end else begin
          cnt_d = cnt_dec(cnt_q);
        end
      end
      `SIA_ST_GAP: begin
        if (cnt_zero(cnt_q)) begin
          st_d = `SIA_ST_IDLE;
        end else begin
          cnt_d = cnt_dec(cnt_q);
        end
      end
      default: begin
        // An unused code drops back to idle rather than sticking
        st_d = `SIA_ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= `SIA_ST_IDLE;
      cnt_q <= {CW{1'b0}};
      pend_q <= 1'b0;
      irq_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      // Looking at the next state lines the pin up with the state register
      irq_n_q <= (st_d != `SIA_ST_PULSE);
    end
  end

  // Every output is a flop, so none can glitch
  assign irq_pulse_out_n_o = irq_n_q;
  assign evt_flags_o = flag_q;
  assign cfg_pulse_en_o = cfg_en_q;
  assign cfg_pulse_long_o = cfg_long_q;
endmodule

// File: bench/sia_irq_assertions.sv
/* Aggregator checker, bound below. Assumes pulses of 4 and 8 cycles. */
module sia_irq_assertions #(
  parameter integer NUM_EVT = 51, parameter integer PULSE_SHORT_CYC = 4,
  parameter integer PULSE_LONG_CYC = 8
) (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire init_phase_i,
  input wire cfg_write_i,
  input wire cfg_pulse_en_i,
  input wire host_irq_cmd_i,
  input wire [NUM_EVT-1:0] flag_clear_i,
  input wire irq_pulse_out_n_o,
  input wire [NUM_EVT-1:0] evt_flags_o,
  input wire cfg_pulse_en_o,
  input wire cfg_pulse_long_o
);
  wire irq_n = irq_pulse_out_n_o;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_short_width: assert property (!cfg_pulse_long_o && $fell(irq_n) |->
    !irq_n [*4] ##1 irq_n) else $error("short width");
  a_long_width: assert property (cfg_pulse_long_o && $fell(irq_n) |->
    !irq_n [*8] ##1 irq_n) else $error("long width");
  a_gap_held: assert property ($rose(irq_n) |-> irq_n [*4]) else $error("gap");
  a_cfg_locked: assert property (!init_phase_i |=>
    $stable({cfg_pulse_en_o, cfg_pulse_long_o})) else $error("config moved");
  a_cfg_taken: assert property (init_phase_i && cfg_write_i |=>
    cfg_pulse_en_o == $past(cfg_pulse_en_i)) else $error("config lost");
  a_host_flag: assert property ($rose(host_irq_cmd_i) |=> evt_flags_o[45])
    else $error("request flag");
  a_flag_sticky: assert property (1'b1 |=>
    (~evt_flags_o & $past(evt_flags_o) & ~$past(flag_clear_i)) == '0) else $error("flag lost");
  a_pulse_cause: assert property ($fell(irq_n) |-> $past(evt_flags_o) != '0)
    else $error("no cause");
  cover property (cfg_pulse_long_o && $fell(irq_n));
  cover property ($rose(evt_flags_o[48]));
  cover property ($rose(evt_flags_o[30]) && !irq_n);
endmodule
bind sia_irq_aggregator sia_irq_assertions #(.NUM_EVT(NUM_EVT),
  .PULSE_SHORT_CYC(PULSE_SHORT_CYC), .PULSE_LONG_CYC(PULSE_LONG_CYC)) u_sia_irq_assertions (
  .ref_clk_i, .rst_b_i, .init_phase_i, .cfg_write_i, .cfg_pulse_en_i, .host_irq_cmd_i,
  .flag_clear_i, .irq_pulse_out_n_o, .evt_flags_o, .cfg_pulse_en_o, .cfg_pulse_long_o);

// File: bench/sia_host_model.sv
/* Host model: counts interrupt pulses, sends SPI frames. Assumes the bench clock. */
module sia_host_model (
  input wire logic ref_clk_i,
  input wire logic irq_pulse_out_n_i,
  output logic chip_select_n_o = 1'h1,
  output logic spi_sclk_o = 1'h0,
  output int pulse_cnt_o = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(negedge irq_pulse_out_n_i) pulse_cnt_o++;
  // Clock idles low between frames; four ref clocks a level suit the syncer
  task automatic frame(input int n);
    chip_select_n_o = 1'h0;
    repeat (2 * n) begin
      repeat (4) @(negedge ref_clk_i);
      spi_sclk_o = ~spi_sclk_o;
    end
    repeat (4) @(negedge ref_clk_i);
    chip_select_n_o = 1'h1;
  endtask
endmodule

// File: bench/testbench.sv
/* Aggregator bench. Assumes host model and checker compiled first. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst_b = 1'h0, init = 1'h1, wr = 1'h0, en = 1'h1, lg = 1'h0;
  logic done = 1'h0, nm = 1'h0, ltf = 1'h1, xp = 1'h1, ms = 1'h1;
  logic [3:0] fv = 4'h9;
  logic [50:0] msk = '0, clr = '0;
  logic [46:0] s = '0;
  wire [50:0] fl;
  wire irq_n, cs_n, sck, en_o, lg_o;
  int err_count = 0, checked = 0, pulses, p;
  always #5 clk = ~clk;
  sia_irq_aggregator #(.NUM_EVT(51), .PULSE_SHORT_CYC(4), .PULSE_LONG_CYC(8)) u_sia_irq_aggregator (
    .ref_clk_i(clk), .rst_b_i(rst_b), .init_phase_i(init), .cfg_write_i(wr), .cfg_pulse_en_i(en),
    .cfg_pulse_long_i(lg), .evt_mask_i(msk), .flag_clear_i(clr), .supply_evt_i(s[2:0]),
    .pre_regulator_evt_i(s[8:3]), .core_evt_i(s[12:9]), .analog_ref_regulator_evt_i(s[19:13]),
    .auxiliary_regulator_evt_i(s[24:20]), .transceiver_supply_evt_i(s[29:25]),
    .gp_input_state_i(s[34:30]), .gp_input_wakeup_i(s[39:35]), .bus_wakeup_event_i(s[40]),
    .transceiver_overtemp_event_i(s[41]), .receive_stuck_recessive_i(s[42]),
    .transmit_stuck_dominant_i(s[43]), .bus_stuck_dominant_i(s[44]), .host_irq_cmd_i(s[45]),
    .long_timer_expiry_event_i(s[46]), .long_timer_func1_i(ltf), .external_pass_i(xp),
    .chip_select_n_i(cs_n), .spi_sclk_i(sck), .main_sm_active_i(ms), .frame_done_i(done),
    .frame_parity_ok_i(fv[3]), .frame_access_bad_i(fv[2]), .frame_init_write_i(fv[1]),
    .frame_secure_ok_i(fv[0]), .normal_mode_i(nm), .irq_pulse_out_n_o(irq_n),
    .evt_flags_o(fl), .cfg_pulse_en_o(en_o), .cfg_pulse_long_o(lg_o));
  sia_host_model u_sia_host_model (.ref_clk_i(clk), .irq_pulse_out_n_i(irq_n),
    .chip_select_n_o(cs_n), .spi_sclk_o(sck), .pulse_cnt_o(pulses));
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic cfg(input logic [1:0] v);
    {en, lg, wr} = {v, 1'h1};
    cyc(1);
    wr = 1'h0;
  endtask
  // Frame kinds: 48 is a short SPI frame, 47, 49 and 50 a frame_done with checks in v; f: flag expected
  task automatic ev(input int i, input int np, input logic [3:0] v = 4'h9,
    input logic f = 1'h1);
    p = pulses;
    if (i < 47) s[i] = 1'h1;
    else if (i == 48) u_sia_host_model.frame(15);
    else {fv, done} = {v, 1'h1};
    cyc(1);
    done = 1'h0;
    cyc(i == 48 ? 8 : 1);
    s = '0;
    fv = 4'h9;
    chk("flag", {3'h0, f}, fl[i]);
    cyc(24);
    chk("pulses", np, pulses - p);
    clr = '1;
    cyc(1);
    clr = '0;
  endtask
  task automatic test_done();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    cyc(12);
    rst_b = 1'h1;
    cyc(1);
    chk("idle", 4'ha, {irq_n, |fl, en_o, lg_o});
    cfg(2'h0);
    ev(45, 0);
    cfg(2'h3);
    ev(45, 1);
    cfg(2'h2);
    init = 1'h0;
    cyc(1);
    cfg(2'h3);
    chk("cfg lock", 4'h0, lg_o);
    msk[45] = 1'h1;
    ev(45, 0);
    msk = '0;
    $display("end config test");
    for (int i = 0; i < 47; i++)
      if (i != 18 && i != 29) begin
        ev(i, (i > 29 && i < 35) ? 2 : 1);
      end
    $display("end source test");
    ev(48, 1);
    u_sia_host_model.frame(16);
    cyc(8);
    chk("clock count", 4'h0, fl[48]);
    ev(50, 1, 4'h1);
    ev(49, 1, 4'hd);
    nm = 1'h1;
    ev(49, 1, 4'hb);
    ev(47, 1, 4'h8);
    $display("end frame test");
    ltf = 1'h0;
    xp = 1'h0;
    ms = 1'h0;
    ev(46, 0, 4'h9, 1'h0);
    ev(19, 0, 4'h9, 1'h0);
    ev(21, 0, 4'h9, 1'h0);
    ev(48, 0, 4'h9, 1'h0);
    ev(50, 0, 4'h1, 1'h0);
    ev(47, 0, 4'h8, 1'h0);
    ev(49, 1, 4'hd);
    $display("end gating test");
    test_done();
  end
endmodule
